// ===== rtl/fnsyn_dev.sv
// Synthesizer end: serial word capture, register bank, reference divider,
// interpolator-driven feedback ratio and fast-lock timer.
// Assumes link wires and reference input arrive asynchronously to clk_sys.
`timescale 1ns/1ps
`default_nettype none
`include "fnsyn_regs.svh"
module fnsyn_dev
  import fnsyn_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  fnsyn_if.dev             link,
  input  wire logic        ref_in,
  output logic             pfd_tick_o,
  output logic [9:0]       div_ratio_o,
  output logic [11:0]      mod_active_o,
  output logic             counter_reset_o,
  output logic             dither_o,
  output logic             fastlock_o,
  output logic [8:0]       cp_units_o,
  output logic [2:0]       mux_sel_o,
  output logic             mux_pin_o,
  output logic             mux_pin_oe_n
);
  localparam int FW = `FN_FRACTION_NUMERATOR_W;

  logic [2:0]  sclk_s, sdat_s, le_s, ref_s;
  logic [23:0] shift_q;
  logic [8:0]  int_q;
  logic [FW-1:0] fraction_numerator_q, mod_pend_q, mod_act_q, timer_q, fl_cnt_q;
  logic [3:0]  rdiv_q, rcnt_q, cp_q;
  logic [2:0]  mux_q;
  logic [8:0]  ns_q;
  logic        dbl_q, crst_q, fl_q, pfd_q;
  logic signed [3:0] sdm_y;

  logic        sclk_rise, le_rise, ref_edge, wr_n, wr_r, wr_c, wr_s, rlast, fl_expire;
  logic [1:0]  sel;
  logic [3:0]  rdiv_eff;
  logic signed [10:0] ratio;

  // Only stage 2 and 3 of each synchroniser are read by logic
  assign sclk_rise = sclk_s[1] & ~sclk_s[2];
  assign le_rise   = le_s[1] & ~le_s[2];
  assign sel       = shift_q[`FN_SEL_LSB +: 2];
  assign wr_n      = le_rise && sel == `FN_SEL_NDIV;
  assign wr_r      = le_rise && sel == `FN_SEL_RDIV;
  assign wr_c      = le_rise && sel == `FN_SEL_CTRL;
  assign wr_s      = le_rise && sel == `FN_SEL_NOISE;
  // Doubler makes both reference edges active, else only the falling edge
  assign ref_edge  = dbl_q ? (ref_s[1] ^ ref_s[2]) : (~ref_s[1] & ref_s[2]);
  assign rdiv_eff  = (rdiv_q == 4'h0) ? 4'h1 : rdiv_q;
  assign rlast     = rcnt_q == rdiv_eff - 4'h1;
  assign fl_expire = fl_q && pfd_q && fl_cnt_q <= 12'h001;
  assign ratio     = $signed({2'b00, int_q}) + 11'(sdm_y);

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      sclk_s <= '0;
      sdat_s <= '0;
      le_s   <= '0;
      ref_s  <= '0;
    end else begin
      sclk_s <= {sclk_s[1:0], link.sclk};
      sdat_s <= {sdat_s[1:0], link.sdata};
      le_s   <= {le_s[1:0], link.le};
      ref_s  <= {ref_s[1:0], ref_in};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) shift_q <= '0;
    else if (sclk_rise) shift_q <= {shift_q[22:0], sdat_s[1]};
  end

  // Register bank
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      int_q      <= '0;
      fraction_numerator_q     <= '0;
      mod_pend_q <= `FN_MOD_RESET;
      mod_act_q  <= `FN_MOD_RESET;
      timer_q    <= '0;
      rdiv_q     <= 4'h1;
      mux_q      <= '0;
      cp_q       <= '0;
      dbl_q      <= 1'b0;
      crst_q     <= 1'b0;
      ns_q       <= '0;
    end else begin
      if (wr_n) begin
        int_q     <= shift_q[`FN_INT_LSB +: `FN_INT_W];
        fraction_numerator_q    <= shift_q[`FN_FRACTION_NUMERATOR_LSB +: FW];
        mod_act_q <= mod_pend_q;
      end
      if (wr_r && shift_q[`FN_LOAD_BIT]) timer_q <= shift_q[`FN_MOD_LSB +: FW];
      if (wr_r && !shift_q[`FN_LOAD_BIT]) begin
        mod_pend_q <= shift_q[`FN_MOD_LSB +: FW];
        rdiv_q     <= shift_q[`FN_R_LSB +: 4];
        mux_q      <= shift_q[`FN_MUX_LSB +: 3];
      end
      if (wr_c) begin
        crst_q <= shift_q[`FN_CRST_BIT];
        cp_q   <= shift_q[`FN_CP_LSB +: 4];
        dbl_q  <= shift_q[`FN_DBL_BIT];
      end
      if (wr_s) ns_q <= shift_q[`FN_NS_LSB +: `FN_NS_W];
    end
  end

  // Reference divider, held while the counters are in reset
  always_ff @(posedge clk_sys) begin
    if (!nrst || crst_q) begin
      rcnt_q <= '0;
      pfd_q  <= 1'b0;
    end else begin
      pfd_q <= ref_edge && rlast;
      if (ref_edge) rcnt_q <= rlast ? 4'h0 : rcnt_q + 4'h1;
    end
  end

  fnsyn_sdm #(.W(FW)) u_sdm (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .clear   (crst_q),
    .step    (pfd_q),
    .fraction_numerator    (fraction_numerator_q),
    .modulus (mod_act_q),
    .dither  (ns_q == `FN_NS_SPUR),
    .y_q     (sdm_y)
  );

  // Fast-lock timer: a fresh N write with the bit set restarts it
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      fl_q     <= 1'b0;
      fl_cnt_q <= '0;
    end else if (wr_n && shift_q[`FN_FL_BIT]) begin
      fl_q     <= timer_q != '0;
      fl_cnt_q <= timer_q;
    end else if (fl_expire) begin
      fl_q     <= 1'b0;
      fl_cnt_q <= '0;
    end else if (fl_q && pfd_q) begin
      fl_cnt_q <= fl_cnt_q - 12'h001;
    end
  end

  // Registered outputs
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      pfd_tick_o      <= 1'b0;
      div_ratio_o     <= '0;
      mod_active_o    <= `FN_MOD_RESET;
      counter_reset_o <= 1'b0;
      dither_o        <= 1'b0;
      fastlock_o      <= 1'b0;
      cp_units_o      <= '0;
      mux_sel_o       <= '0;
      mux_pin_o       <= 1'b0;
      mux_pin_oe_n    <= 1'b1;
    end else begin
      pfd_tick_o      <= pfd_q;
      if (pfd_q) div_ratio_o <= ratio[9:0];
      mod_active_o    <= mod_act_q;
      counter_reset_o <= crst_q;
      dither_o        <= ns_q == `FN_NS_SPUR;
      fastlock_o      <= fl_q && !fl_expire;
      // Pump current in units; sixteenfold while wide bandwidth holds
      cp_units_o      <= (fl_q && !fl_expire) ? 9'({5'h00, cp_q} + 9'h001) * 9'(`FN_CP_BOOST)
                                            : 9'({5'h00, cp_q} + 9'h001);
      mux_sel_o       <= mux_q;
      mux_pin_o       <= 1'b0;
      // Open-drain switch to ground only when routed and fast lock is live
      mux_pin_oe_n    <= !(fl_q && !fl_expire && mux_q == `FN_MUX_FL);
    end
  end
endmodule : fnsyn_dev
`default_nettype wire

// ===== rtl/fnsyn_regs.svh
// Word layout, reset values and timing counts of the fractional-N programming link.
// Assumes a 200 MHz system clock and 24-bit words sent MSB first.
// Summary of operation
// - Host writes reserved bits as zero
// - First write clears noise/spur register
// - Then noise/spur mode; 0003c7 selects low noise
// - Counter reset, R-div, N-div, release reset
// - Output equals rate times integer plus fraction
// - Rate is ref times doubler over R
// - Host keeps comparison rate within 32 MHz
// - Third-order interpolator, denominator 2 to 4095
// - Dithered mode needs denominator at least 50
// - Interpolator steps once per comparison cycle
// - Undithered repeat length follows denominator factors
// - Dithered repeat length is 2^21 cycles
// - Load bit set: field is timer
// - Wide bandwidth lasts timer comparison cycles
// - After timer: noise/spur, then control
// - R-div with mux 110 routes switch out
// - N-div with fast-lock bit starts fast lock
// - Later jumps repeat only the N-div write
// - Fast lock raises pump current sixteenfold
// - Fast lock grounds mux pin if selected
// - New denominator applies after N-div write
// - Two low bits select register; 11 noise/spur
`ifndef FNSYN_REGS_SVH
`define FNSYN_REGS_SVH
`define FN_WORD_W      24
`define FN_SEL_LSB     0
`define FN_SEL_NDIV    2'h0
`define FN_SEL_RDIV    2'h1
`define FN_SEL_CTRL    2'h2
`define FN_SEL_NOISE   2'h3
`define FN_FL_BIT      23
`define FN_LOAD_BIT    23
`define FN_INT_LSB     14
`define FN_INT_W       9
`define FN_FRACTION_NUMERATOR_LSB    2
`define FN_MOD_LSB     2
`define FN_FRACTION_NUMERATOR_W      12
`define FN_MUX_LSB     20
`define FN_MUX_FL      3'h6
`define FN_R_LSB       14
`define FN_CRST_BIT    2
`define FN_CP_LSB      7
`define FN_DBL_BIT     11
`define FN_NS_LSB      2
`define FN_NS_W        9
`define FN_NS_SPUR     9'h000
`define FN_NS_LOWNOISE 24'h0003c7
`define FN_MOD_RESET   12'h002
`define FN_CP_BOOST    16
`define FN_CLK_PS      5000
`define FN_SCLK_HALF_PS 25000
`define FN_SCLK_HALF_CYC ((`FN_SCLK_HALF_PS + `FN_CLK_PS - 1) / `FN_CLK_PS)
`endif

// ===== rtl/fnsyn_pkg.sv
// Types shared by both ends of the fractional-N programming link.
// Assumes fnsyn_regs.svh is on the include path.
package fnsyn_pkg;
  typedef enum logic [1:0] {
    FNSYN_OP_INIT = 2'h0,
    FNSYN_OP_FLSETUP = 2'h1,
    FNSYN_OP_JUMP = 2'h2,
    FNSYN_OP_RAW = 2'h3
  } fnsyn_op_type;
  typedef enum logic [3:0] {
    FNSYN_IDLE  = 4'b0001,
    FNSYN_SHIFT = 4'b0010,
    FNSYN_LATCH = 4'b0100,
    FNSYN_GAP   = 4'b1000
  } fnsyn_state_type;
endpackage : fnsyn_pkg

// ===== rtl/fnsyn_if.sv
// Three-wire serial link between host controller and synthesizer.
// Host drives every wire; the synthesizer only listens.
`timescale 1ns/1ps
`default_nettype none
interface fnsyn_if;
  logic sclk;
  logic sdata;
  logic le;
  modport host (output sclk, output sdata, output le);
  modport dev  (input sclk, input sdata, input le);
endinterface : fnsyn_if
`default_nettype wire

// ===== rtl/fnsyn_sdm.sv
// Third-order cascaded sigma-delta interpolator with optional LFSR dither.
// Assumes step pulses at the comparison rate and denominator of 2 or more.
`timescale 1ns/1ps
`default_nettype none
module fnsyn_sdm #(
  parameter int W = 12
) (
  input  wire logic                clk_sys,
  input  wire logic                nrst,
  input  wire logic                clear,
  input  wire logic                step,
  input  wire logic [W-1:0]        fraction_numerator,
  input  wire logic [W-1:0]        modulus,
  input  wire logic                dither,
  output logic signed [3:0]        y_q
);
  // Modular accumulate: returns carry and remainder
  function automatic logic [W:0] mod_add(input logic [W-1:0] a, input logic [W-1:0] b,
                                         input logic [W-1:0] m);
    logic [W:0] s;
    s = {1'b0, a} + {1'b0, b};
    if (s >= {1'b0, m}) mod_add = {1'b1, W'(s - {1'b0, m})};
    else mod_add = {1'b0, s[W-1:0]};
  endfunction : mod_add

  logic [W-1:0] acc1_q, acc2_q, acc3_q;
  logic         c2_q, c3_q, c3_qq;
  logic [20:0]  lfsr_q;
  logic [W-1:0] in1;
  logic [W:0]   s1, s2, s3;
  logic signed [3:0] y_d;

  // Dither nudges the first stage LSB; 21-bit LFSR gives the long period
  assign in1 = fraction_numerator + W'(dither & lfsr_q[0]);
  assign s1  = mod_add(acc1_q, in1, modulus);
  assign s2  = mod_add(acc2_q, s1[W-1:0], modulus);
  assign s3  = mod_add(acc3_q, s2[W-1:0], modulus);
  // Noise-shaped carry combination; undithered period is set by the denominator
  assign y_d = 4'(s1[W]) + 4'(s2[W]) - 4'(c2_q) + 4'(s3[W]) - 4'({c3_q, 1'b0})
             + 4'(c3_qq);

  always_ff @(posedge clk_sys) begin
    if (!nrst || clear) begin
      acc1_q <= '0;
      acc2_q <= '0;
      acc3_q <= '0;
      c2_q   <= 1'b0;
      c3_q   <= 1'b0;
      c3_qq  <= 1'b0;
      lfsr_q <= 21'h000001;
      y_q    <= 4'sh0;
    end else if (step) begin
      acc1_q <= s1[W-1:0];
      acc2_q <= s2[W-1:0];
      acc3_q <= s3[W-1:0];
      c2_q   <= s2[W];
      c3_q   <= s3[W];
      c3_qq  <= c3_q;
      lfsr_q <= {lfsr_q[19:0], lfsr_q[20] ^ lfsr_q[18]};
      y_q    <= y_d;
    end
  end
endmodule : fnsyn_sdm
`default_nettype wire

// ===== rtl/fnsyn_host.sv
// Host end: builds programming sequences from user settings and shifts each
// 24-bit word out MSB first, then pulses the latch enable.
// Assumes the synthesizer samples the wires with its own clock.
`timescale 1ns/1ps
`default_nettype none
`include "fnsyn_regs.svh"
module fnsyn_host
  import fnsyn_pkg::*;
(
  input  wire logic         clk_sys,
  input  wire logic         nrst,
  fnsyn_if.host             link,
  input  wire logic         op_valid,
  input  wire fnsyn_op_type op_code,
  input  wire logic [8:0]   int_val,
  input  wire logic [11:0]  fraction_numerator_val,
  input  wire logic [11:0]  mod_val,
  input  wire logic [11:0]  timer_val,
  input  wire logic [3:0]   rdiv_val,
  input  wire logic [3:0]   cp_val,
  input  wire logic         doubler,
  input  wire logic [8:0]   noise_mode,
  input  wire logic [23:0]  raw_word,
  output logic              op_ready,
  output logic              busy
);
  localparam int HC = `FN_SCLK_HALF_CYC;

  fnsyn_state_type st_q;
  fnsyn_op_type    op_q;
  logic [2:0]  step_q;
  logic [4:0]  bit_q;
  logic [7:0]  div_q;
  logic [23:0] word_q;
  logic        sclk_q, sdata_q, le_q;
  logic [23:0] cur_word;
  logic        last_step, half;

  // Reserved positions stay zero because words are built field by field
  function automatic logic [23:0] ctrl_word(input logic crst);
    ctrl_word = 24'({doubler, 4'h0} | 5'h00) << `FN_DBL_BIT - 4 | 24'(cp_val) << `FN_CP_LSB
              | 24'(crst) << `FN_CRST_BIT | 24'(`FN_SEL_CTRL);
  endfunction : ctrl_word
  function automatic logic [23:0] rdiv_word(input logic fl_mux);
    rdiv_word = 24'(fl_mux ? `FN_MUX_FL : 3'h0) << `FN_MUX_LSB | 24'(rdiv_val) << `FN_R_LSB
              | 24'(mod_val) << `FN_MOD_LSB | 24'(`FN_SEL_RDIV);
  endfunction : rdiv_word
  function automatic logic [23:0] ndiv_word(input logic fl);
    ndiv_word = 24'(fl) << `FN_FL_BIT | 24'(int_val) << `FN_INT_LSB
              | 24'(fraction_numerator_val) << `FN_FRACTION_NUMERATOR_LSB | 24'(`FN_SEL_NDIV);
  endfunction : ndiv_word

  logic [23:0] ns_word;
  assign ns_word = 24'(noise_mode) << `FN_NS_LSB | 24'(`FN_SEL_NOISE);

  always_comb begin
    cur_word = raw_word;
    unique case (op_q)
      FNSYN_OP_INIT: begin
        unique case (step_q)
          3'h0: cur_word = 24'(`FN_SEL_NOISE);
          3'h1: cur_word = ns_word;
          3'h2: cur_word = ctrl_word(1'b1);
          3'h3: cur_word = rdiv_word(1'b0);
          3'h4: cur_word = ndiv_word(1'b0);
          default: cur_word = ctrl_word(1'b0);
        endcase
      end
      FNSYN_OP_FLSETUP: begin
        unique case (step_q)
          3'h0: cur_word = 24'h1 << `FN_LOAD_BIT | 24'(timer_val) << `FN_MOD_LSB
                         | 24'(`FN_SEL_RDIV);
          3'h1: cur_word = ns_word;
          3'h2: cur_word = ctrl_word(1'b0);
          3'h3: cur_word = rdiv_word(1'b1);
          default: cur_word = ndiv_word(1'b1);
        endcase
      end
      FNSYN_OP_JUMP: cur_word = ndiv_word(1'b1);
      FNSYN_OP_RAW:  cur_word = raw_word;
    endcase
  end

  assign last_step = (op_q == FNSYN_OP_INIT) ? step_q == 3'h5
                   : (op_q == FNSYN_OP_FLSETUP) ? step_q == 3'h4 : 1'b1;
  // Half-period tick keeps the serial clock within its rated speed
  assign half = div_q == 8'(HC - 1);

  always_ff @(posedge clk_sys) begin
    if (!nrst) div_q <= '0;
    else if (st_q == FNSYN_IDLE || half) div_q <= '0;
    else div_q <= div_q + 8'h01;
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      st_q     <= FNSYN_IDLE;
      op_q     <= FNSYN_OP_RAW;
      step_q   <= '0;
      bit_q    <= '0;
      word_q   <= '0;
      sclk_q   <= 1'b0;
      sdata_q  <= 1'b0;
      le_q     <= 1'b0;
      op_ready <= 1'b0;
      busy     <= 1'b0;
    end else begin
      unique case (st_q)
        FNSYN_IDLE: begin
          op_ready <= 1'b1;
          busy     <= 1'b0;
          if (op_valid && op_ready) begin
            op_q     <= op_code;
            step_q   <= '0;
            op_ready <= 1'b0;
            busy     <= 1'b1;
            st_q     <= FNSYN_GAP;
          end
        end
        FNSYN_GAP: if (half) begin
          word_q  <= cur_word;
          bit_q   <= 5'd23;
          sdata_q <= cur_word[23];
          st_q    <= FNSYN_SHIFT;
        end
        FNSYN_SHIFT: if (half) begin
          sclk_q <= !sclk_q;
          if (sclk_q) begin
            if (bit_q == 5'd0) st_q <= FNSYN_LATCH;
            else begin
              bit_q   <= bit_q - 5'd1;
              sdata_q <= word_q[bit_q - 5'd1];
            end
          end
        end
        FNSYN_LATCH: if (half) begin
          le_q <= !le_q;
          if (le_q) begin
            if (last_step) st_q <= FNSYN_IDLE;
            else begin
              step_q <= step_q + 3'h1;
              st_q   <= FNSYN_GAP;
            end
          end
        end
      endcase
    end
  end

  assign link.sclk  = sclk_q;
  assign link.sdata = sdata_q;
  assign link.le    = le_q;
endmodule : fnsyn_host
`default_nettype wire

// ===== tb/fnsyn_chk.sv
// Concurrent checks on the serial link wires and the fast-lock outputs.
// Instantiated beside the link interface; every input is a plain signal.
`timescale 1ns/1ps
`default_nettype none
module fnsyn_chk (
  input wire logic       clk_sys,
  input wire logic       nrst,
  input wire logic       sclk,
  input wire logic       sdata,
  input wire logic       le,
  input wire logic       pfd_tick_o,
  input wire logic       fastlock_o,
  input wire logic [8:0] cp_units_o,
  input wire logic [2:0] mux_sel_o,
  input wire logic       mux_pin_o,
  input wire logic       mux_pin_oe_n
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  chk_latch_width: assert property ($rose(le) |-> le[*5] ##1 !le)
    else $error("latch pulse width wrong");
  chk_clk_high: assert property ($rose(sclk) |-> sclk[*5] ##1 !sclk)
    else $error("serial clock high phase wrong");
  chk_data_hold: assert property (sclk && $past(sclk) |-> $stable(sdata))
    else $error("serial data moved while clock high");
  chk_latch_idle: assert property (le |-> !sclk)
    else $error("serial clock high during latch");
  chk_tick_pulse: assert property (pfd_tick_o |=> !pfd_tick_o)
    else $error("comparison tick longer than one cycle");
  // Transition cycles are skipped; pump and flag are registered from one condition and change on the same edge
  chk_boost_units: assert property (fastlock_o && $past(fastlock_o)
    |-> cp_units_o[3:0] == 4'h0 && cp_units_o != 9'h000)
    else $error("pump current not boosted in fast lock");
  chk_normal_units: assert property (!fastlock_o && !$past(fastlock_o)
    |-> cp_units_o <= 9'h010)
    else $error("pump current boosted outside fast lock");
  chk_pin_ground: assert property (fastlock_o && $past(fastlock_o) && mux_sel_o == 3'h6
    |-> !mux_pin_oe_n)
    else $error("output pin not grounded in fast lock");
  chk_pin_release: assert property (!fastlock_o && !$past(fastlock_o) |-> mux_pin_oe_n)
    else $error("output pin grounded outside fast lock");
  chk_pin_level: assert property (mux_pin_o == 1'b0)
    else $error("output pin driven high");
  // Flag and tick leave the same output edge, so the ending tick is seen with the fall
  chk_fl_expiry: assert property ($fell(fastlock_o)
    |-> pfd_tick_o)
    else $error("fast lock ended away from a tick");
  cov_fast_lock: cover property ($rose(fastlock_o));
  cov_pin_ground: cover property (!mux_pin_oe_n);
  cov_word_latch: cover property ($rose(le));
endmodule : fnsyn_chk
`default_nettype wire

// ===== tb/fracn_program_fastlock_ctrl_tb.sv
// Host and synthesizer ends joined by the link; bench drives host user side.
// Assumes a free-running reference input at 10 MHz, unrelated to clk_sys.
`timescale 1ns/1ps
`default_nettype none
module fracn_program_fastlock_ctrl_tb
  import fnsyn_pkg::*;
;
  logic         clk_sys = 1'b0;
  logic         nrst = 1'b0;
  logic         ref_in = 1'b1;
  logic         op_valid = 1'b0;
  fnsyn_op_type op_code = FNSYN_OP_RAW;
  logic [8:0]   int_val = 9'h08a;
  logic [8:0]   noise_mode = 9'h0f1;
  logic [11:0]  fraction_numerator_val = 12'h01e;
  logic [11:0]  mod_val = 12'h041;
  logic [11:0]  timer_val = 12'h008;
  logic [3:0]   rdiv_val = 4'h1;
  logic [3:0]   cp_val = 4'h3;
  logic         doubler = 1'b0;
  logic [23:0]  raw_word = 24'h000000;
  logic         op_ready, busy, pfd_tick_o, counter_reset_o, dither_o, fastlock_o;
  logic         mux_pin_o, mux_pin_oe_n;
  logic [9:0]   div_ratio_o;
  logic [11:0]  mod_active_o;
  logic [8:0]   cp_units_o;
  logic [2:0]   mux_sel_o;
  int           failures = 0;
  int           check_count = 0;
  int           c, s;
  logic         fl_prev = 1'b0;
  int           fl_ticks = 0;

  always #2.5 clk_sys = ~clk_sys;
  // Reference period is 20 clk_sys cycles, so one tick per 20 cycles at R=1
  always #50 ref_in = ~ref_in;

  // Ticks of one wide-bandwidth spell, from its first tick to the one that ends it
  always @(posedge clk_sys) begin
    fl_prev <= fastlock_o;
    if (fastlock_o === 1'b1 && fl_prev !== 1'b1) fl_ticks <= (pfd_tick_o === 1'b1) ? 1 : 0;
    else if (pfd_tick_o === 1'b1 && (fastlock_o === 1'b1 || fl_prev === 1'b1))
      fl_ticks <= fl_ticks + 1;
  end

  fnsyn_if i_fnsyn_if ();
  fnsyn_host i_fnsyn_host (.clk_sys(clk_sys), .nrst(nrst), .link(i_fnsyn_if.host),
    .op_valid(op_valid), .op_code(op_code), .int_val(int_val), .fraction_numerator_val(fraction_numerator_val),
    .mod_val(mod_val), .timer_val(timer_val), .rdiv_val(rdiv_val), .cp_val(cp_val),
    .doubler(doubler), .noise_mode(noise_mode), .raw_word(raw_word),
    .op_ready(op_ready), .busy(busy));
  fnsyn_dev i_fnsyn_dev (.clk_sys(clk_sys), .nrst(nrst), .link(i_fnsyn_if.dev),
    .ref_in(ref_in), .pfd_tick_o(pfd_tick_o), .div_ratio_o(div_ratio_o),
    .mod_active_o(mod_active_o), .counter_reset_o(counter_reset_o), .dither_o(dither_o),
    .fastlock_o(fastlock_o), .cp_units_o(cp_units_o), .mux_sel_o(mux_sel_o),
    .mux_pin_o(mux_pin_o), .mux_pin_oe_n(mux_pin_oe_n));
  fnsyn_chk i_fnsyn_chk (.clk_sys(clk_sys), .nrst(nrst), .sclk(i_fnsyn_if.sclk),
    .sdata(i_fnsyn_if.sdata), .le(i_fnsyn_if.le), .pfd_tick_o(pfd_tick_o),
    .fastlock_o(fastlock_o), .cp_units_o(cp_units_o), .mux_sel_o(mux_sel_o),
    .mux_pin_o(mux_pin_o), .mux_pin_oe_n(mux_pin_oe_n));

  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  task automatic chk_int(input string what, input int exp, input int got, input int tol);
    check_count++;
    if (got < exp - tol || got > exp + tol) begin
      failures++;
      $display("Error %s expected %0d seen %0d", what, exp, got);
    end
  endtask : chk_int

  // Values are read at the edge itself, i.e. what the design sampled there
  task automatic run_op(input fnsyn_op_type op);
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (op_ready !== 1'b1 && n < 100);
    op_code <= op;
    op_valid <= 1'b1;
    @(posedge clk_sys);
    op_valid <= 1'b0;
    @(posedge clk_sys);
    chk("busy", 12'h001, {11'h000, busy});
    n = 0;
    while (busy !== 1'b0 && n < 20000) begin
      @(posedge clk_sys);
      n++;
    end
    chk("done", 12'h000, {11'h000, busy});
    repeat (8) @(posedge clk_sys);
  endtask : run_op

  task automatic raw(input logic [23:0] w);
    raw_word <= w;
    run_op(FNSYN_OP_RAW);
  endtask : raw

  // Counts ticks and sums the divide codes seen on them
  task automatic watch(input int cyc, input logic fl_only, input int lim,
                       output int cnt, output int sum);
    cnt = 0;
    sum = 0;
    for (int n = 0; n < cyc && cnt < lim; n++) begin
      @(posedge clk_sys);
      if (fl_only && fastlock_o !== 1'b1) break;
      if (pfd_tick_o === 1'b1) begin
        cnt++;
        sum += int'(div_ratio_o);
      end
    end
  endtask : watch

  task automatic test_init();
    run_op(FNSYN_OP_INIT);
    chk("counter_reset", 12'h000, {11'h000, counter_reset_o});
    chk("dither", 12'h000, {11'h000, dither_o});
    chk("mod_active", 12'h041, mod_active_o);
    chk("cp_units", 12'h004, {3'h0, cp_units_o});
    watch(400, 1'b0, 1000, c, s);
    chk_int("ticks_r1", 20, c, 1);
    watch(100, 1'b0, 3, c, s);
    // Period divides 65 for an odd denominator not divisible by three
    watch(2000, 1'b0, 65, c, s);
    chk_int("code_sum", 138 * 65 + 30, s, 0);
  endtask : test_init

  task automatic test_rate();
    raw(24'h000982);
    watch(400, 1'b0, 1000, c, s);
    chk_int("ticks_dbl", 40, c, 1);
    raw(24'h000182);
    raw(24'h008105);
    watch(400, 1'b0, 1000, c, s);
    chk_int("ticks_r2", 10, c, 1);
    raw(24'h000186);
    chk("counter_reset_on", 12'h001, {11'h000, counter_reset_o});
    raw(24'h000182);
  endtask : test_rate

  task automatic test_modulus();
    raw(24'h007ffd);
    chk("mod_held", 12'h041, mod_active_o);
    raw(24'h228000);
    chk("mod_taken", 12'hfff, mod_active_o);
    watch(200, 1'b0, 4, c, s);
    chk("div_ratio", 12'h08a, {2'h0, div_ratio_o});
  endtask : test_modulus

  task automatic test_dither();
    raw(24'h000003);
    chk("dither_on", 12'h001, {11'h000, dither_o});
    raw(24'h0003c7);
    chk("dither_off", 12'h000, {11'h000, dither_o});
  endtask : test_dither

  task automatic test_fastlock();
    mod_val <= 12'h082;
    run_op(FNSYN_OP_FLSETUP);
    chk("mod_fl", 12'h082, mod_active_o);
    chk("fastlock", 12'h001, {11'h000, fastlock_o});
    chk("mux_sel", 12'h006, {9'h000, mux_sel_o});
    chk("pin_oe_n", 12'h000, {11'h000, mux_pin_oe_n});
    chk("cp_boost", 12'h040, {3'h0, cp_units_o});
    watch(1000, 1'b1, 1000, c, s);
    @(posedge clk_sys);
    chk_int("fl_ticks", 8, fl_ticks, 0);
    chk("fl_end", 12'h000, {11'h000, fastlock_o});
    chk("cp_normal", 12'h004, {3'h0, cp_units_o});
    chk("pin_free", 12'h001, {11'h000, mux_pin_oe_n});
    run_op(FNSYN_OP_JUMP);
    chk("fl_again", 12'h001, {11'h000, fastlock_o});
    watch(1000, 1'b1, 1000, c, s);
    @(posedge clk_sys);
    chk_int("fl_ticks2", 8, fl_ticks, 0);
  endtask : test_fastlock

  task automatic tally_and_finish();
    if (failures == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    #250000;
    failures++;
    tally_and_finish();
  end

  initial begin
    repeat (6) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    chk("oe_n_reset", 12'h001, {11'h000, mux_pin_oe_n});
    chk("mod_reset", 12'h002, mod_active_o);
    test_init();
    test_rate();
    test_modulus();
    test_dither();
    test_fastlock();
    tally_and_finish();
  end
endmodule : fracn_program_fastlock_ctrl_tb
`default_nettype wire
